// ===== common/trbg_map.vh
// Purpose: register offsets, field positions, reset values and timing for the random byte block
// Assumes: byte addresses on a 32-bit Avalon-MM slave, 20 MHz clock
// Notes: times are in microseconds; cycle counts derive from the clock rate
`ifndef TRBG_MAP_VH
`define TRBG_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TRBG_OFF_START 12'h000
`define TRBG_OFF_STOP 12'h004
`define TRBG_OFF_FLAG 12'h100
`define TRBG_OFF_SHORT 12'h200
`define TRBG_OFF_IENSET 12'h304
`define TRBG_OFF_IENCLR 12'h308
`define TRBG_OFF_CONFIG 12'h504
`define TRBG_OFF_VALUE 12'h508

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define TRBG_BIT_TRIGGER 0
`define TRBG_BIT_FLAG 0
`define TRBG_BIT_SHORT 0
`define TRBG_BIT_IEN 0
`define TRBG_BIT_BIAS 0
`define TRBG_RST_FLAG 1'b0
`define TRBG_RST_SHORT 1'b0
`define TRBG_RST_IEN 1'b0
`define TRBG_RST_BIAS 1'b0
`define TRBG_RST_VALUE 8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TRBG_CLK_MHZ 20
`define TRBG_T_START_US 128
`define TRBG_T_RAW_US 30
`define TRBG_T_BC_US 120
`define TRBG_START_CYC (`TRBG_T_START_US * `TRBG_CLK_MHZ)
`define TRBG_RAW_BIT_CYC ((`TRBG_T_RAW_US * `TRBG_CLK_MHZ) / 8)
`define TRBG_BC_PAIR_CYC ((`TRBG_T_BC_US * `TRBG_CLK_MHZ) / 32)

`endif

// ===== logic/trbg_top.v
// Purpose: true random byte generator with task, event, shortcut and interrupt registers
// Assumes: single clock, Avalon-MM slave with waitrequest, noise bit is a synchronous input
// Notes: generation timing is derived from counters; noise bits come from outside
//
// Notes on behaviour
// - writing the start trigger begins random generation
// - writing the stop trigger ends random generation
// - while running each new byte overwrites the output and raises the ready event
// - ready flag is bit 0 at 0x100, one after a new byte, resets to zero
// - shortcut bit set makes every ready event stop the generator
// - writing one at 0x304 enables the ready interrupt; reads show the enable
// - writing one at 0x308 disables the ready interrupt; reads show the enable
// - configuration register at 0x504 selects bias correction
// - bias correction removes ones or zeros bias, generating more slowly
// - processed bits gather in an eight bit register read in parallel
// - a start waits a fixed start-up delay once before generation begins
// - without correction each byte takes the raw per-byte time
// - with correction byte time is unbounded; discarded pairs lengthen it
//
// Register access over Avalon-MM was left to the implementer.
`include "trbg_map.vh"

module trbg_top #(
  parameter START_CYCLES = `TRBG_START_CYC,
  parameter RAW_BIT_CYCLES = `TRBG_RAW_BIT_CYC,
  parameter BC_PAIR_CYCLES = `TRBG_BC_PAIR_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire noise_bit,
  output reg irq
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_WARM = 2'd1;
  localparam ST_RUN = 2'd2;

  reg [1:0] state_reg;
  reg [15:0] count_reg;
  reg flag_reg;
  reg short_reg;
  reg ien_reg;
  reg bias_reg;
  reg [7:0] value_reg;
  reg [7:0] shift_reg;
  reg [2:0] nbits_reg;
  reg first_reg;
  reg first_val_reg;
  reg ack_reg;

  // ----------------------------------------------------------------
  // bus access
  // ----------------------------------------------------------------
  // one wait cycle per access: waitrequest drops the cycle after the request appears
  wire access = (avs_read | avs_write) & ~ack_reg;
  wire wr = avs_write & access;
  wire rd = avs_read & access;
  wire lane0 = avs_byteenable[0];

  function hit;
    input [11:0] off;
    begin
      hit = wr & lane0 & (avs_address == off);
    end
  endfunction

  wire wr_start = hit(`TRBG_OFF_START) & avs_writedata[`TRBG_BIT_TRIGGER];
  wire wr_stop = hit(`TRBG_OFF_STOP) & avs_writedata[`TRBG_BIT_TRIGGER];

  // ----------------------------------------------------------------
  // generator
  // ----------------------------------------------------------------
  wire [15:0] period = bias_reg ? BC_PAIR_CYCLES[15:0] : RAW_BIT_CYCLES[15:0];
  wire tick = (state_reg == ST_RUN) && (count_reg == 16'h0000);
  // corrected mode: unequal pair gives first bit, equal pair is dropped
  wire bit_ok = bias_reg ? (first_reg & (first_val_reg != noise_bit)) : 1'b1;
  wire bit_val = bias_reg ? first_val_reg : noise_bit;
  wire take = tick & bit_ok;
  wire byte_done = take & (nbits_reg == 3'd7);
  wire stop_now = wr_stop | (byte_done & short_reg);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      count_reg <= 16'h0000;
      shift_reg <= 8'h00;
      nbits_reg <= 3'd0;
      first_reg <= 1'b0;
      first_val_reg <= 1'b0;
      value_reg <= `TRBG_RST_VALUE;
    end else begin
      if (byte_done) begin
        value_reg <= {shift_reg[6:0], bit_val};
      end
      if (take) begin
        shift_reg <= {shift_reg[6:0], bit_val};
        nbits_reg <= nbits_reg + 3'd1;
      end
      if (tick) begin
        count_reg <= period - 16'h0001;
        if (bias_reg) begin
          first_reg <= ~first_reg;
          first_val_reg <= noise_bit;
        end
      end else if (count_reg != 16'h0000) begin
        count_reg <= count_reg - 16'h0001;
      end
      case (state_reg)
        ST_IDLE: begin
          if (wr_start && !wr_stop) begin
            state_reg <= ST_WARM;
            count_reg <= START_CYCLES[15:0] - 16'h0001;
          end
        end
        ST_WARM: begin
          if (wr_stop) begin
            state_reg <= ST_IDLE;
          end else if (count_reg == 16'h0000) begin
            state_reg <= ST_RUN;
            count_reg <= period - 16'h0001;
            nbits_reg <= 3'd0;
            first_reg <= 1'b0;
          end
        end
        ST_RUN: begin
          if (stop_now) begin
            state_reg <= ST_IDLE;
            count_reg <= 16'h0000;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers and interrupt
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= `TRBG_RST_FLAG;
      short_reg <= `TRBG_RST_SHORT;
      ien_reg <= `TRBG_RST_IEN;
      bias_reg <= `TRBG_RST_BIAS;
      irq <= 1'b0;
      ack_reg <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      ack_reg <= access;
      avs_waitrequest <= ~access;
      // a new byte in the clearing cycle keeps the flag set
      if (byte_done) begin
        flag_reg <= 1'b1;
      end else if (hit(`TRBG_OFF_FLAG)) begin
        flag_reg <= avs_writedata[`TRBG_BIT_FLAG];
      end
      if (hit(`TRBG_OFF_SHORT)) begin
        short_reg <= avs_writedata[`TRBG_BIT_SHORT];
      end
      if (hit(`TRBG_OFF_IENSET) && avs_writedata[`TRBG_BIT_IEN]) begin
        ien_reg <= 1'b1;
      end else if (hit(`TRBG_OFF_IENCLR) && avs_writedata[`TRBG_BIT_IEN]) begin
        ien_reg <= 1'b0;
      end
      if (hit(`TRBG_OFF_CONFIG)) begin
        bias_reg <= avs_writedata[`TRBG_BIT_BIAS];
      end
      irq <= (byte_done | flag_reg) & ien_reg &
             ~(hit(`TRBG_OFF_FLAG) & ~avs_writedata[0] & ~byte_done) &
             ~(hit(`TRBG_OFF_IENCLR) & avs_writedata[0]) |
             (byte_done | flag_reg) & hit(`TRBG_OFF_IENSET) & avs_writedata[0];
      if (rd) begin
        case (avs_address)
          `TRBG_OFF_FLAG: avs_readdata <= {31'h00000000, flag_reg};
          `TRBG_OFF_SHORT: avs_readdata <= {31'h00000000, short_reg};
          `TRBG_OFF_IENSET: avs_readdata <= {31'h00000000, ien_reg};
          `TRBG_OFF_IENCLR: avs_readdata <= {31'h00000000, ien_reg};
          `TRBG_OFF_CONFIG: avs_readdata <= {31'h00000000, bias_reg};
          `TRBG_OFF_VALUE: avs_readdata <= {24'h000000, value_reg};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // trbg_top

// ===== tb/trbg_properties.sv
// Purpose: port-level checks for trbg_top
// Assumes: one clock domain, asynchronous active-low reset
// Notes: a request is taken while waitrequest is still high
module trbg_properties (
  input wire clk,
  input wire rst_n,
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire noise_bit,
  input wire irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd_t = avs_read && avs_waitrequest;
  wire wr1 = avs_write && avs_waitrequest && avs_byteenable[0] && avs_writedata[0];
  property p_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer one cycle after request");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("waitrequest low for more than a cycle");
  property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_hold; avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved outside an answer");
  property p_flag; rd_t && avs_address == 12'h100 |=> avs_readdata[31:1] == 31'h0; endproperty
  a_flag: assert property (p_flag) else $error("flag upper bits set");
  property p_val; rd_t && avs_address == 12'h508 |=> avs_readdata[31:8] == 24'h0; endproperty
  a_val: assert property (p_val) else $error("value wider than a byte");
  property p_ien;
    rd_t && (avs_address == 12'h304 || avs_address == 12'h308) |=> avs_readdata[31:1] == 31'h0;
  endproperty
  a_ien: assert property (p_ien) else $error("enable upper bits set");
  property p_off; wr1 && avs_address == 12'h308 |-> ##2 !irq; endproperty
  a_off: assert property (p_off) else $error("irq high after disable");
  property p_unm; rd_t && avs_address == 12'h00C |=> avs_readdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  c_irq: cover property ($rose(irq));
  c_start: cover property (wr1 && avs_address == 12'h000);
  c_val: cover property (rd_t && avs_address == 12'h508);
endmodule // trbg_properties

// ===== tb/true_random_byte_generator_test.sv
// Purpose: self-checking bench for trbg_top
// Assumes: shortened generator counts; noise driven by the bench
// Notes: constant noise makes raw bytes predictable and starves bias correction
module true_random_byte_generator_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ST = 100;
  localparam int RB = 3;
  logic clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, noise_bit = 0, rnd = 0;
  logic noise_lvl = 0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, irq;
  logic [11:0] regs [6] = '{12'h100, 12'h200, 12'h304, 12'h308, 12'h504, 12'h00C};
  int num_errors = 0, compares = 0, seed = 67, n, m_ien = 0;
  trbg_top #(.START_CYCLES(ST), .RAW_BIT_CYCLES(RB), .BC_PAIR_CYCLES(RB)) dut_u (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .noise_bit(noise_bit),
    .irq(irq));
  initial forever #25 clk = ~clk;
  // single driver for the noise pin: a fixed level or one random bit per edge
  always @(posedge clk) noise_bit <= rnd ? 1'($random(seed)) : noise_lvl;
  task complete_run;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // hold the request until waitrequest is seen low at a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(0, a, 0);
    chk(q, e);
  endtask
  // two idle edges first so a just-written cause reaches irq
  task wirq(input int lim, input logic e);
    n = 0;
    repeat (2) @(posedge clk);
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(irq, e);
  endtask
  initial begin
    #2000000;
    num_errors++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    foreach (regs[i]) rd(regs[i], 0);
    avs_byteenable <= 4'hE;
    xfer(1, 12'h304, 1);
    avs_byteenable <= 4'hF;
    rd(12'h304, 0);
    xfer(1, 12'h304, 1);
    m_ien = 1;
    rd(12'h308, m_ien);
    $display("test registers done");
    noise_lvl <= 1;
    xfer(1, 12'h200, 1);
    xfer(1, 12'h000, 1);
    wirq(3000, 1);
    chk(n > ST - 4 && n < ST + 8 * RB + 10, 1);
    rd(12'h508, 32'hFF);
    rd(12'h100, 1);
    xfer(1, 12'h100, 0);
    wirq(200, 0);
    rd(12'h100, 0);
    $display("test shortcut done");
    xfer(1, 12'h200, 0);
    noise_lvl <= 0;
    xfer(1, 12'h000, 1);
    wirq(3000, 1);
    rd(12'h508, 0);
    xfer(1, 12'h100, 0);
    wirq(3000, 1);
    chk(n < ST, 1);
    xfer(1, 12'h308, 1);
    m_ien = 0;
    wirq(100, 0);
    rd(12'h304, m_ien);
    xfer(1, 12'h004, 1);
    xfer(1, 12'h100, 0);
    xfer(1, 12'h304, 1);
    m_ien = 1;
    wirq(300, 0);
    $display("test continuous done");
    xfer(1, 12'h504, 1);
    rd(12'h504, 1);
    noise_lvl <= 1;
    xfer(1, 12'h000, 1);
    wirq(600, 0);
    rnd <= 1;
    wirq(3000, 1);
    chk(n >= 12 * RB, 1);
    xfer(1, 12'h004, 1);
    $display("test bias done");
    complete_run;
  end
endmodule // true_random_byte_generator_test
bind trbg_top trbg_properties chk_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .noise_bit(noise_bit), .irq(irq));
